// ---- hdl/dag_top.sv ----
// Data address generator: operand decode, pointer pairs, memory port
`timescale 1ns/1ps
`default_nettype none
module dag_top
  import dag_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  wire logic [15:0] op_word,
  input  wire logic        op_is_write,
  input  wire logic [7:0]  op_wdata,
  input  wire logic [7:0]  w_val,
  input  wire logic [3:0]  bank_select,
  input  wire logic        extended_set_enable,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_en,
  output logic             mem_we,
  output logic      [11:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             rd_valid,
  output logic      [7:0]  rd_data,
  output logic             dest_file,
  output logic             is_byte_add
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dag_state_t  st;
    logic [11:0] p0;
    logic [11:0] p1;
    logic [11:0] p2;
    logic        mem_en;
    logic        mem_we;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        dest;
    logic        add;
    logic        zero_rd;
  } dag_regs_t;
  dag_regs_t s_q;
  dag_regs_t s_d;

  // True when an address falls among the virtual operands
  function automatic logic is_virtual(input logic [11:0] a);
    is_virtual = (a >= DAG_VIRT_BASE) && (a <= DAG_VIRT_TOP)
                 && (a[2:0] >= DAG_K_ACCUMULATOR_OFFSET_OPERAND);
  endfunction : is_virtual

  // Pair index of a special-register address, 3 when none
  function automatic logic [1:0] pair_of(input logic [11:0] a);
    logic [11:0] off;
    off = a - DAG_PAIR_BASE;
    if (a < DAG_PAIR_BASE || a > DAG_VIRT_TOP) pair_of = 2'd3;
    else if (off < 12'd8)  pair_of = 2'd2;
    else if (off < 12'd16) pair_of = 2'd1;
    else                   pair_of = 2'd0;
  endfunction : pair_of

  // Kind within a pair block: low, high, one of five operands, or 0 in the eighth slot
  function automatic logic [2:0] kind_of(input logic [11:0] a);
    logic [11:0] off;
    off = a - DAG_PAIR_BASE;
    kind_of = off[2:0] + 3'd1;
  endfunction : kind_of

  // ----------------------------------------------------------------
  // Direct address formation
  // ----------------------------------------------------------------
  logic [7:0]  f_fld;
  logic        a_bit;
  logic [11:0] dir_addr;
  assign f_fld = op_word[7:0];
  assign a_bit = op_word[8];
  always_comb begin
    if (a_bit)
      dir_addr = {bank_select, f_fld};
    else if (extended_set_enable && f_fld <= DAG_IDX_LIMIT)
      dir_addr = s_q.p2 + {4'h0, f_fld};
    else if (f_fld > DAG_IDX_LIMIT)
      dir_addr = {DAG_TOP_BANK, f_fld};
    else
      dir_addr = {4'h0, f_fld};
  end

  // Target is a virtual operand or pointer byte
  logic [1:0]  tp;
  logic [2:0]  tk;
  logic [11:0] tp_ptr;
  assign tp = pair_of(dir_addr);
  assign tk = kind_of(dir_addr);
  always_comb begin
    unique case (tp)
      2'd0:    tp_ptr = s_q.p0;
      2'd1:    tp_ptr = s_q.p1;
      default: tp_ptr = s_q.p2;
    endcase
  end

  // Pairs zero and one never see the extended set
  logic [11:0] ind_addr;
  logic [11:0] ind_next;
  dag_ptr_arith u_arith (
    .ptr      (tp_ptr),
    .w_val    (w_val),
    .kind     (tk),
    .addr     (ind_addr),
    .next_ptr (ind_next)
  );

  logic tgt_is_opnd;
  assign tgt_is_opnd = (tp != 2'd3) && (tk >= DAG_K_ACCUMULATOR_OFFSET_OPERAND);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [11:0] eff;
  logic [11:0] newp;
  always_comb begin
    s_d          = s_q;
    s_d.mem_en   = 1'b0;
    s_d.mem_we   = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.zero_rd  = 1'b0;
    eff          = dir_addr;
    newp         = tp_ptr;
    unique case (s_q.st)
      DAG_IDLE: begin
        if (op_valid) begin
          s_d.dest = op_word[9];
          s_d.add  = op_word[15:10] == DAG_BYTE_ADD_TO_ACCUMULATOR_OP;
          if (tgt_is_opnd) begin
            eff  = ind_addr;
            newp = ind_next;
          end
          // Writes through an operand into its own pair load it as-is
          if (tgt_is_opnd && op_is_write && pair_of(eff) == tp
              && kind_of(eff) >= DAG_K_ACCUMULATOR_OFFSET_OPERAND) begin
            newp = {4'h0, op_wdata};
          end
          if (tgt_is_opnd) begin
            unique case (tp)
              2'd0:    s_d.p0 = newp;
              2'd1:    s_d.p1 = newp;
              default: s_d.p2 = newp;
            endcase
          end
          s_d.mem_addr  = eff;
          s_d.mem_wdata = op_wdata;
          if (tgt_is_opnd && is_virtual(eff)) begin
            s_d.zero_rd = ~op_is_write;
            s_d.st      = op_is_write ? DAG_IDLE : DAG_READ;
          end else if (pair_of(eff) != 2'd3 && kind_of(eff) inside {DAG_K_LOW, DAG_K_HIGH}) begin
            // Direct byte access to a pointer register
            if (op_is_write) begin
              unique case (pair_of(eff))
                2'd0: s_d.p0 = kind_of(eff) == DAG_K_LOW ?
                        {s_q.p0[11:8], op_wdata} : {op_wdata[3:0], s_q.p0[7:0]};
                2'd1: s_d.p1 = kind_of(eff) == DAG_K_LOW ?
                        {s_q.p1[11:8], op_wdata} : {op_wdata[3:0], s_q.p1[7:0]};
                default: s_d.p2 = kind_of(eff) == DAG_K_LOW ?
                        {s_q.p2[11:8], op_wdata} : {op_wdata[3:0], s_q.p2[7:0]};
              endcase
            end else begin
              s_d.rd_valid = 1'b1;
              s_d.rd_data  = kind_of(eff) == DAG_K_LOW ? tp_of_byte(eff, 1'b0)
                                                      : tp_of_byte(eff, 1'b1);
            end
          end else begin
            s_d.mem_en = 1'b1;
            s_d.mem_we = op_is_write;
            s_d.st     = op_is_write ? DAG_IDLE : DAG_READ;
          end
        end
      end
      DAG_READ: begin
        s_d.rd_valid = 1'b1;
        s_d.rd_data  = s_q.zero_rd ? DAG_READ_ZERO : mem_rdata;
        s_d.st       = DAG_IDLE;
      end
      DAG_WRITE: s_d.st = DAG_IDLE;
      default:   s_d.st = DAG_IDLE;
    endcase
  end

  // Byte view of a pair for direct reads, high nibble reads zero
  function automatic logic [7:0] tp_of_byte(input logic [11:0] a, input logic hi);
    logic [11:0] p;
    unique case (pair_of(a))
      2'd0:    p = s_q.p0;
      2'd1:    p = s_q.p1;
      default: p = s_q.p2;
    endcase
    tp_of_byte = hi ? {4'h0, p[11:8]} : p[7:0];
  endfunction : tp_of_byte

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.st       <= DAG_IDLE;
      s_q.p0       <= DAG_PTR_RESET;
      s_q.p1       <= DAG_PTR_RESET;
      s_q.p2       <= DAG_PTR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_en      = s_q.mem_en;
  assign mem_we      = s_q.mem_we;
  assign mem_addr    = s_q.mem_addr;
  assign mem_wdata   = s_q.mem_wdata;
  assign rd_valid    = s_q.rd_valid;
  assign rd_data     = s_q.rd_data;
  assign dest_file   = s_q.dest;
  assign is_byte_add = s_q.add;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Sampled views for the checks; sums kept as nets so $past sees a signal
  logic        chk_take;
  logic [11:0] chk_bank;
  logic [11:0] chk_p2;
  logic [11:0] chk_idx;
  logic [11:0] chk_wext;
  assign chk_take = op_valid && s_q.st == DAG_IDLE;
  assign chk_bank = {bank_select, f_fld};
  assign chk_p2   = s_q.p2;
  assign chk_idx  = chk_p2 + {4'h0, f_fld};
  assign chk_wext = {{4{w_val[7]}}, w_val};

  // Value of one pair; state passed in so the checks see it sampled
  function automatic logic [11:0] pair_val(input dag_regs_t s, input logic [1:0] n);
    unique case (n)
      2'd0:    pair_val = s.p0;
      2'd1:    pair_val = s.p1;
      default: pair_val = s.p2;
    endcase
  endfunction : pair_val

  property p_virt_read_zero;
    @(posedge ref_clk) disable iff (rst)
      (s_q.st == DAG_READ && s_q.zero_rd) |=> (rd_valid && rd_data == 8'h00);
  endproperty
  a_virt_read_zero: assert property (p_virt_read_zero) else $error("virtual read not zero");
  property p_virt_write_nop;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && tgt_is_opnd && op_is_write && is_virtual(ind_addr))
      |=> !mem_en;
  endproperty
  a_virt_write_nop: assert property (p_virt_write_nop) else $error("virtual write reached memory");
  property p_bank_mode;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && a_bit && !tgt_is_opnd && pair_of(dir_addr) == 2'd3)
      |=> (mem_addr == $past(chk_bank));
  endproperty
  a_bank_mode: assert property (p_bank_mode) else $error("bank address wrong");
  property p_high_nibble;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && !op_is_write && !tgt_is_opnd
       && pair_of(dir_addr) != 2'd3 && kind_of(dir_addr) == DAG_K_HIGH)
      |=> (rd_valid && rd_data[7:4] == 4'h0);
  endproperty
  a_high_nibble: assert property (p_high_nibble) else $error("pointer high nibble not zero");
  property p_dest;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE) |=> (dest_file == $past(op_word[9]));
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit lost");
  property p_byte_add_to_accumulator;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && op_word[15:10] == 6'b0010_01) |=> is_byte_add;
  endproperty
  a_byte_add_to_accumulator: assert property (p_byte_add_to_accumulator) else $error("byte add not decoded");
  property p_top_bank;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && !a_bit && f_fld > 8'h5f && !tgt_is_opnd
       && pair_of(dir_addr) == 2'd3) |=> (mem_addr[11:8] == 4'hf);
  endproperty
  a_top_bank: assert property (p_top_bank) else $error("top bank not used");
  property p_idx;
    @(posedge ref_clk) disable iff (rst)
      (op_valid && s_q.st == DAG_IDLE && !a_bit && extended_set_enable && f_fld <= 8'h5f
       && !tgt_is_opnd && pair_of(dir_addr) == 2'd3)
      |=> (mem_addr == $past(chk_idx));
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  property p_post_inc;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !op_is_write && tgt_is_opnd && tk == DAG_K_POST_INCREMENT_OPERAND)
      |=> (mem_addr == $past(tp_ptr)
           && pair_val(s_q, $past(tp)) == $past(tp_ptr) + 12'h001);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment step wrong");
  property p_post_dec;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !op_is_write && tgt_is_opnd && tk == DAG_K_POST_DECREMENT_OPERAND)
      |=> (mem_addr == $past(tp_ptr)
           && pair_val(s_q, $past(tp)) == $past(tp_ptr) - 12'h001);
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement step wrong");
  property p_pre_inc;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !op_is_write && tgt_is_opnd && tk == DAG_K_PRE_INCREMENT_OPERAND)
      |=> (mem_addr == $past(tp_ptr) + 12'h001
           && pair_val(s_q, $past(tp)) == $past(tp_ptr) + 12'h001);
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre-increment step wrong");
  property p_plain;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !op_is_write && tgt_is_opnd && tk == DAG_K_PLAIN)
      |=> (mem_addr == $past(tp_ptr) && pair_val(s_q, $past(tp)) == $past(tp_ptr));
  endproperty
  a_plain: assert property (p_plain) else $error("plain operand moved pointer");
  property p_accumulator_offset_operand;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !op_is_write && tgt_is_opnd && tk == DAG_K_ACCUMULATOR_OFFSET_OPERAND)
      |=> (mem_addr == $past(tp_ptr) + $past(chk_wext)
           && pair_val(s_q, $past(tp)) == $past(tp_ptr));
  endproperty
  a_accumulator_offset_operand: assert property (p_accumulator_offset_operand) else $error("offset operand wrong");
  property p_own_write;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && op_is_write && tgt_is_opnd && pair_of(ind_addr) == tp
       && kind_of(ind_addr) >= DAG_K_ACCUMULATOR_OFFSET_OPERAND)
      |=> (!mem_en && pair_val(s_q, $past(tp)) == {4'h0, $past(op_wdata)});
  endproperty
  a_own_write: assert property (p_own_write) else $error("own operand write not loaded");
  property p_window;
    @(posedge ref_clk) disable iff (rst)
      (chk_take && !a_bit && extended_set_enable && f_fld <= DAG_IDX_LIMIT && !tgt_is_opnd)
      |=> ((mem_addr - $past(chk_p2)) <= 12'h05f);
  endproperty
  a_window: assert property (p_window) else $error("indexed window overrun");
  c_read: cover property (@(posedge ref_clk) disable iff (rst) rd_valid);
  c_write: cover property (@(posedge ref_clk) disable iff (rst) mem_we);
  c_zero: cover property (@(posedge ref_clk) disable iff (rst) s_q.zero_rd);
  c_own: cover property (@(posedge ref_clk) disable iff (rst)
    chk_take && op_is_write && tgt_is_opnd && pair_of(ind_addr) == tp);
  c_window: cover property (@(posedge ref_clk) disable iff (rst)
    chk_take && !a_bit && extended_set_enable && f_fld <= DAG_IDX_LIMIT);
endmodule : dag_top
`default_nettype wire

// ---- hdl/dag_pkg.sv ----
// Constants and types for the data address generator
package dag_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [11:0] DAG_VIRT_BASE   = 12'h0fd9;
  localparam logic [11:0] DAG_VIRT_TOP    = 12'h0fef;
  localparam logic [11:0] DAG_OPND_ONE    = 12'h0fe7; // plain_operand_one
  localparam logic [11:0] DAG_PAIR_BASE   = 12'h0fd9;
  localparam logic [7:0]  DAG_IDX_LIMIT   = 8'h5f;
  localparam logic [3:0]  DAG_TOP_BANK    = 4'hf;
  localparam logic [5:0]  DAG_BYTE_ADD_TO_ACCUMULATOR_OP    = 6'b0010_01;
  localparam logic [11:0] DAG_PTR_RESET   = 12'h0000;
  localparam logic [7:0]  DAG_READ_ZERO   = 8'h00;
  // Operand kinds inside each pair's block of virtual registers
  localparam logic [2:0]  DAG_K_ACCUMULATOR_OFFSET_OPERAND     = 3'd3;
  localparam logic [2:0]  DAG_K_PRE_INCREMENT_OPERAND    = 3'd4;
  localparam logic [2:0]  DAG_K_POST_DECREMENT_OPERAND   = 3'd5;
  localparam logic [2:0]  DAG_K_POST_INCREMENT_OPERAND   = 3'd6;
  localparam logic [2:0]  DAG_K_PLAIN     = 3'd7;
  localparam logic [2:0]  DAG_K_LOW       = 3'd1;
  localparam logic [2:0]  DAG_K_HIGH      = 3'd2;
  typedef enum logic [2:0] {
    DAG_IDLE  = 3'b001,
    DAG_READ  = 3'b010,
    DAG_WRITE = 3'b100
  } dag_state_t;
endpackage : dag_pkg

// ---- hdl/dag_ptr_arith.sv ----
// Pointer arithmetic for one pair: offset sum and step
`timescale 1ns/1ps
`default_nettype none
module dag_ptr_arith
  import dag_pkg::*;
(
  input  wire logic [11:0] ptr,
  input  wire logic [7:0]  w_val,
  input  wire logic [2:0]  kind,
  output logic      [11:0] addr,
  output logic      [11:0] next_ptr
);
  logic [11:0] inc;
  logic [11:0] dec;
  // Whole twelve-bit add so low byte carry reaches high nibble
  assign inc = ptr + 12'h001;
  assign dec = ptr - 12'h001;
  // Address and updated pointer, no flags produced at all
  always_comb begin
    addr     = ptr;
    next_ptr = ptr;
    unique case (kind)
      DAG_K_POST_DECREMENT_OPERAND: next_ptr = dec;
      DAG_K_POST_INCREMENT_OPERAND: next_ptr = inc;
      DAG_K_PRE_INCREMENT_OPERAND: begin
        addr     = inc;
        next_ptr = inc;
      end
      DAG_K_ACCUMULATOR_OFFSET_OPERAND: addr = ptr + {{4{w_val[7]}}, w_val};
      default: ;
    endcase
  end
endmodule : dag_ptr_arith
`default_nettype wire

// ---- bench/dag_mem_model.sv ----
// Behavioural data memory seen from the generator's memory port
`timescale 1ns/1ps
`default_nettype none
module dag_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_en,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  // ------------------------------------------------------------
  // Storage and read port
  // ------------------------------------------------------------
  logic [7:0] ram [4096];
  logic [7:0] last_q = 8'h00;
  // Seed bytes from the low eight address bits so bytes differ within each 256-byte page
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = i[7:0] ^ 8'h5a;
    end
  end
  // Unselected port shows the inverse of the last byte, never stale data
  assign mem_rdata = (mem_en && !mem_we) ? ram[mem_addr] : ~last_q;
  // Writes land on the edge; reads remember their byte
  always @(posedge ref_clk) begin
    if (mem_en && mem_we) begin
      ram[mem_addr] <= mem_wdata;
    end
    if (mem_en && !mem_we) begin
      last_q <= ram[mem_addr];
    end
  end
endmodule : dag_mem_model
`default_nettype wire

// ---- bench/data_address_generator_tb.sv ----
// Self-checking bench for the data address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module data_address_generator_tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0;
  logic        op_is_write = 1'b0;
  logic        extended_set_enable = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic [7:0]  op_wdata = 8'h00;
  logic [7:0]  w_val = 8'h00;
  logic [3:0]  bank_select = 4'h0;
  logic [7:0]  mem_rdata, mem_wdata, rd_data, seen_data;
  logic [11:0] mem_addr, seen_addr;
  logic        mem_en, mem_we, rd_valid, dest_file, is_byte_add, seen_we, seen_rd;
  int          fails = 0;
  int          samples_checked = 0;
  dag_top dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_word(op_word),
    .op_is_write(op_is_write), .op_wdata(op_wdata), .w_val(w_val),
    .bank_select(bank_select), .extended_set_enable(extended_set_enable),
    .mem_rdata(mem_rdata), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .dest_file(dest_file), .is_byte_add(is_byte_add));
  dag_mem_model mem (.ref_clk(ref_clk), .mem_en(mem_en), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  // Byte-add word, result to file, access bit as given
  function automatic logic [15:0] op(input logic a, input logic [7:0] f);
    return {6'h09, 1'b1, a, f};
  endfunction : op
  // One request, then four settled cycles; also covers the idle gap after a read
  task automatic acc(input logic [15:0] w, input logic wr, input logic [7:0] wd);
    @(posedge ref_clk);
    #1;
    op_word = w;
    op_is_write = wr;
    op_wdata = wd;
    op_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    op_valid = 1'b0;
    seen_we = 1'b0;
    seen_rd = 1'b0;
    seen_addr = 12'hxxx;
    seen_data = 8'hxx;
    repeat (4) begin
      if (mem_en === 1'b1) begin
        seen_we = mem_we;
        seen_addr = mem_addr;
      end
      if (rd_valid === 1'b1) begin
        seen_rd = 1'b1;
        seen_data = rd_data;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask : acc
  task automatic wr(input logic [7:0] f, input logic [7:0] v);
    acc(op(1'b0, f), 1'b1, v);
  endtask : wr
  task automatic setp(input logic [7:0] f, input logic [11:0] p);
    wr(f, p[7:0]);
    wr(f + 8'h01, {4'h0, p[11:8]});
  endtask : setp
  task automatic byte_is(input logic [7:0] f, input logic [7:0] e);
    acc(op(1'b0, f), 1'b0, 8'h00);
    `CHK("rd_valid", 1'b1, seen_rd);
    `CHK("rd_data", e, seen_data);
  endtask : byte_is
  // Read through an operand; memory bytes follow the seeded pattern
  task automatic via(input logic [15:0] w, input logic [11:0] e);
    acc(w, 1'b0, 8'h00);
    `CHK("mem_addr", e, seen_addr);
    `CHK("rd_data", e[7:0] ^ 8'h5a, seen_data);
  endtask : via
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    `CHK("mem_en", 1'b0, mem_en);
    byte_is(8'he9, 8'h00);
    `CHK("is_byte_add", 1'b1, is_byte_add);
    `CHK("dest_file", 1'b1, dest_file);
    acc({6'h1a, 2'b00, 8'he9}, 1'b0, 8'h00);
    `CHK("is_byte_add", 1'b0, is_byte_add);
    `CHK("dest_file", 1'b0, dest_file);
  endtask : t_reset
  task automatic t_direct;
    wr(8'he9, 8'h34);
    wr(8'hea, 8'ha2);
    byte_is(8'he9, 8'h34);
    byte_is(8'hea, 8'h02);
  endtask : t_direct
  // Bank select set to junk: indirect targets must not notice
  task automatic t_steps;
    bank_select = 4'h9;
    setp(8'he9, 12'h0ff);
    via(op(1'b0, 8'hee), 12'h0ff);
    byte_is(8'he9, 8'h00);
    byte_is(8'hea, 8'h01);
    via(op(1'b0, 8'hed), 12'h100);
    byte_is(8'he9, 8'hff);
    via(op(1'b0, 8'hec), 12'h100);
    via(op(1'b0, 8'hef), 12'h100);
    w_val = 8'h80;
    via(op(1'b0, 8'heb), 12'h080);
    w_val = 8'h7f;
    via(op(1'b0, 8'heb), 12'h17f);
    byte_is(8'he9, 8'h00);
  endtask : t_steps
  task automatic t_wrap;
    setp(8'he9, 12'hfff);
    via(op(1'b0, 8'hee), 12'hfff);
    byte_is(8'hea, 8'h00);
    via(op(1'b0, 8'hed), 12'h000);
    byte_is(8'hea, 8'h0f);
    acc(op(1'b0, 8'hed), 1'b1, 8'h99);
    `CHK("mem_addr", 12'hfff, seen_addr);
    `CHK("mem_we", 1'b1, seen_we);
    byte_is(8'he9, 8'hfe);
  endtask : t_wrap
  // Pair zero aimed at pair one's plain operand
  task automatic t_virtual;
    setp(8'he9, 12'hfe7);
    acc(op(1'b0, 8'hef), 1'b0, 8'h00);
    `CHK("rd_data", 8'h00, seen_data);
    acc(op(1'b0, 8'hef), 1'b1, 8'h55);
    `CHK("mem_we", 1'b0, seen_we);
    byte_is(8'he1, 8'h00);
  endtask : t_virtual
  // Pair two aimed at its own operands: a write loads the pair unstepped
  task automatic t_own;
    setp(8'hd9, 12'hfdd);
    wr(8'hdd, 8'h3c);
    `CHK("mem_we", 1'b0, seen_we);
    byte_is(8'hd9, 8'h3c);
    byte_is(8'hda, 8'h00);
    setp(8'hd9, 12'hfdf);
    wr(8'hdf, 8'h40);
    byte_is(8'hd9, 8'h40);
  endtask : t_own
  // Pair two holds 040h from the previous scenario
  task automatic t_ext;
    extended_set_enable = 1'b1;
    bank_select = 4'h3;
    via(op(1'b0, 8'h5f), 12'h09f);
    via(op(1'b0, 8'h00), 12'h040);
    via(op(1'b0, 8'h60), 12'hf60);
    via(op(1'b1, 8'h5f), 12'h35f);
    wr(8'h05, 8'h77);
    `CHK("mem_addr", 12'h045, seen_addr);
    `CHK("mem_we", 1'b1, seen_we);
    `CHK("mem_wdata", 8'h77, mem_wdata);
    byte_is(8'h05, 8'h77);
    setp(8'he9, 12'h123);
    via(op(1'b0, 8'hef), 12'h123);
  endtask : t_ext
  // ------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ------------------------------------------------------------
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_direct;
    t_steps;
    t_wrap;
    t_virtual;
    t_own;
    t_ext;
    test_done;
  end
  // About 50 requests of six cycles each; some seventeen times that is ample
  initial begin
    #25000;
    fails++;
    test_done;
  end
endmodule : data_address_generator_tb
`default_nettype wire
